// *** rtl/rts_pkg.sv ***
package rts_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FIRST_TIMER = 8'h04;
  localparam logic [7:0] ADDR_SECOND_TIMER = 8'h08;
  localparam logic [7:0] ADDR_RXTO = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_PINMAP = 8'h1C;
  localparam logic [7:0] ADDR_EVENTS = 8'h20;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_HALT = 1;
  localparam int CTRL_IDLE_SEL = 2;
  localparam int CTRL_FSTART_LO = 3;
  localparam int CTRL_LPCHOICE = 5;
  localparam int CTRL_FIDLE = 6;
  localparam int CTRL_FRX_LO = 7;
  localparam int CTRL_FRXTO_LO = 10;
  localparam int CTRL_FTX = 12;
  localparam int CTRL_BEACON = 13;
  localparam int CTRL_PMAP = 14;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  // Transition and pin mapping encodings
  localparam logic [1:0] START_TO_LPSEL = 2'h0;
  localparam logic [2:0] RX_OFF_ON_SYNC = 3'h5;
  localparam logic [2:0] RX_OFF_ON_PRE = 3'h6;
  localparam logic [1:0] RXTO_TO_LPSEL = 2'h2;
  localparam logic [1:0] PIN_MAP_00 = 2'h0;
  localparam logic [1:0] PIN_MAP_01 = 2'h1;
  localparam logic [1:0] PIN_MAP_11 = 2'h3;
  // Interrupt status bits
  localparam int IRQ_PRE = 0;
  localparam int IRQ_SYNC = 1;
  localparam int IRQ_SENT = 2;
  localparam int IRQ_RXTO = 3;
  localparam int IRQ_T1 = 4;
  localparam int IRQ_N = 5;
  // Timing: timer tick is the shortest first-timer step
  localparam int CLK_MHZ = 40;
  localparam int TIMER_MIN_US = 64;
  localparam int TICK_CYCLES = TIMER_MIN_US * CLK_MHZ;
  localparam int TICK_W = 12;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_LPSEL, SEQ_IDLE, SEQ_RX, SEQ_TX
  } rts_state_t;
endpackage : rts_pkg

// *** rtl/rts_timer_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface rts_timer_if;
  logic load;
  logic [15:0] count;
  logic expired;
  modport ctrl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface : rts_timer_if
`default_nettype wire

// *** rtl/rts_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module rts_timer (
  input wire logic sys_clk,
  input wire logic rst,
  rts_timer_if.tmr bus
);
  logic [rts_pkg::TICK_W-1:0] pre;
  logic [15:0] remain;
  logic running;
  wire tickEnd = (pre == rts_pkg::TICK_LAST);
  // Count of zero is treated as one tick, so expiry always happens
  assign bus.expired = running && tickEnd && (remain <= 16'h0001);
  always_ff @(posedge sys_clk) begin
    if (rst || bus.load) begin
      pre <= '0;
      remain <= bus.count;
      running <= bus.load && !rst;
    end else if (running) begin
      pre <= tickEnd ? '0 : pre + 1'b1;
      if (tickEnd) begin
        remain <= remain - 16'h0001;
        if (remain <= 16'h0001) running <= 1'b0;
      end
    end
  end
endmodule : rts_timer
`default_nettype wire

// *** rtl/rts_top.sv ***
// Overview of operation
// - Listen: preamble, then sync, else receiver off
// - Idle wakes every T1+T2, rx only timeout
// - Preamble found: stay rx until second_timer ends
// - Sync match: interrupt, sequencer off, stay rx
// - Encodings for idle, start, lowpower, idle exits
// - Receive transition 101 stops on sync
// - Rx-timeout transition 10 returns to lowpower select
// - First timer minimum duration is 64 us
// - Beacon transmits each T1+T2, idles after sent
// - Transmit transition 0 returns on packet sent
// - Beacon reuses FIFO when beacon bit set
// - Beacon loops until host sets halt bit
// - Pin mapping codes route event flags
// - Receive transition 110 stops on preamble
// - Sleep idle keeps only RC oscillator running
`timescale 1ns/100ps
`default_nettype none
module rts_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic preamble_found,
  input wire logic sync_match,
  input wire logic packet_done_tx,
  input wire logic crc_good,
  input wire logic fifo_threshold_flag,
  input wire logic fifo_empty_flag,
  output logic rx_on,
  output logic tx_on,
  output logic sleep_on,
  output logic rc_osc_only,
  output logic fifo_reuse,
  output logic [4:0] gp_pin,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers for radio event flags
  // Edges are taken after the second stage so one slow pin edge counts once
  logic [5:0] evMeta;
  logic [5:0] evSync;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evMeta <= '0;
      evSync <= '0;
    end else begin
      evMeta <= {fifo_empty_flag, fifo_threshold_flag, crc_good, packet_done_tx,
                 sync_match, preamble_found};
      evSync <= evMeta;
    end
  end
  logic [2:0] evPrev;
  always_ff @(posedge sys_clk) begin
    if (rst) evPrev <= '0;
    else evPrev <= evSync[2:0];
  end
  wire preRise = evSync[0] && !evPrev[0];
  wire syncRise = evSync[1] && !evPrev[1];
  wire sentRise = evSync[2] && !evPrev[2];

  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0] ctrl;
  logic [15:0] timer1Val;
  logic [15:0] timer2Val;
  logic [15:0] rxtoVal;
  logic [rts_pkg::IRQ_N-1:0] irqStat;
  logic [rts_pkg::IRQ_N-1:0] irqMask;
  logic [7:0] pinMap;
  logic [rts_pkg::IRQ_N-1:0] evSet;
  rts_pkg::rts_state_t state;

  wire idleSel = ctrl[rts_pkg::CTRL_IDLE_SEL];
  wire [1:0] start_transition = ctrl[rts_pkg::CTRL_FSTART_LO +: 2];
  wire lpChoice = ctrl[rts_pkg::CTRL_LPCHOICE];
  wire idle_transition = ctrl[rts_pkg::CTRL_FIDLE];
  wire [2:0] fromRx = ctrl[rts_pkg::CTRL_FRX_LO +: 3];
  wire [1:0] fromRxto = ctrl[rts_pkg::CTRL_FRXTO_LO +: 2];
  wire fromTx = ctrl[rts_pkg::CTRL_FTX];
  wire beaconEn = ctrl[rts_pkg::CTRL_BEACON];
  wire pmapBit = ctrl[rts_pkg::CTRL_PMAP];

  ////////////////////////////////////////////////////////////////////////
  // AXI write: address and data taken in either order, held until both present
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire awHave = awHeld || awFire;
  wire wHave = wHeld || wFire;
  wire [7:0] wrAddr = awHeld ? awAddr : s_axi_awaddr;
  wire [31:0] wrData = wHeld ? wData : s_axi_wdata;
  wire [3:0] wrStrb = wHeld ? wStrb : s_axi_wstrb;
  wire doWrite = awHave && wHave && !s_axi_bvalid;
  wire [31:0] wrMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};
  wire wrHit = (wrAddr == rts_pkg::ADDR_CTRL) || (wrAddr == rts_pkg::ADDR_FIRST_TIMER) ||
               (wrAddr == rts_pkg::ADDR_SECOND_TIMER) || (wrAddr == rts_pkg::ADDR_RXTO) ||
               (wrAddr == rts_pkg::ADDR_IRQ_STAT) || (wrAddr == rts_pkg::ADDR_IRQ_MASK) ||
               (wrAddr == rts_pkg::ADDR_PINMAP);
  wire wrCtrl = doWrite && (wrAddr == rts_pkg::ADDR_CTRL);
  wire [31:0] ctrlMerged = (ctrl & ~wrMask) | (wrData & wrMask);
  wire hostStart = wrCtrl && ctrlMerged[rts_pkg::CTRL_START];
  wire hostHalt = wrCtrl && ctrlMerged[rts_pkg::CTRL_HALT];
  wire [rts_pkg::IRQ_N-1:0] stClr = (doWrite && (wrAddr == rts_pkg::ADDR_IRQ_STAT) && wrStrb[0])
      ? wrData[rts_pkg::IRQ_N-1:0] : '0;
  // Byte lanes without a strobe keep their old value
  wire [15:0] t1Merged = (timer1Val & ~wrMask[15:0]) | (wrData[15:0] & wrMask[15:0]);
  wire [15:0] t2Merged = (timer2Val & ~wrMask[15:0]) | (wrData[15:0] & wrMask[15:0]);
  wire [15:0] toMerged = (rxtoVal & ~wrMask[15:0]) | (wrData[15:0] & wrMask[15:0]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (awFire) awAddr <= s_axi_awaddr;
      if (wFire) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      awHeld <= doWrite ? 1'b0 : awHave;
      wHeld <= doWrite ? 1'b0 : wHave;
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= rts_pkg::CTRL_RESET;
      timer1Val <= 16'h0001;
      timer2Val <= 16'h0001;
      rxtoVal <= 16'h0001;
      irqMask <= '0;
      pinMap <= '0;
    end else if (doWrite) begin
      // Start and halt are self-clearing command bits
      if (wrAddr == rts_pkg::ADDR_CTRL) ctrl <= ctrlMerged & 32'hFFFFFFFC;
      if (wrAddr == rts_pkg::ADDR_FIRST_TIMER) timer1Val <= t1Merged;
      if (wrAddr == rts_pkg::ADDR_SECOND_TIMER) timer2Val <= t2Merged;
      if (wrAddr == rts_pkg::ADDR_RXTO) rxtoVal <= toMerged;
      if (wrAddr == rts_pkg::ADDR_IRQ_MASK && wrStrb[0]) irqMask <= wrData[rts_pkg::IRQ_N-1:0];
      if (wrAddr == rts_pkg::ADDR_PINMAP && wrStrb[0]) pinMap <= wrData[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) irqStat <= '0;
    else irqStat <= (irqStat & ~stClr) | evSet;
  end
  assign irq = |(irqStat & irqMask);

  ////////////////////////////////////////////////////////////////////////
  // AXI read
  // Read data is registered with rvalid, so it stands until rready
  logic [31:0] rdMux;
  wire rdHit = (s_axi_araddr == rts_pkg::ADDR_CTRL) || (s_axi_araddr == rts_pkg::ADDR_FIRST_TIMER) ||
               (s_axi_araddr == rts_pkg::ADDR_SECOND_TIMER) || (s_axi_araddr == rts_pkg::ADDR_RXTO) ||
               (s_axi_araddr == rts_pkg::ADDR_STATE) || (s_axi_araddr == rts_pkg::ADDR_IRQ_STAT) ||
               (s_axi_araddr == rts_pkg::ADDR_IRQ_MASK) || (s_axi_araddr == rts_pkg::ADDR_PINMAP) ||
               (s_axi_araddr == rts_pkg::ADDR_EVENTS);
  always_comb begin
    case (s_axi_araddr)
      rts_pkg::ADDR_CTRL: rdMux = ctrl;
      rts_pkg::ADDR_FIRST_TIMER: rdMux = {16'h0000, timer1Val};
      rts_pkg::ADDR_SECOND_TIMER: rdMux = {16'h0000, timer2Val};
      rts_pkg::ADDR_RXTO: rdMux = {16'h0000, rxtoVal};
      rts_pkg::ADDR_STATE: rdMux = {29'h00000000, state};
      rts_pkg::ADDR_IRQ_STAT: rdMux = {27'h0000000, irqStat};
      rts_pkg::ADDR_IRQ_MASK: rdMux = {27'h0000000, irqMask};
      rts_pkg::ADDR_PINMAP: rdMux = {24'h000000, pinMap};
      rts_pkg::ADDR_EVENTS: rdMux = {26'h0000000, evSync};
      default: rdMux = 32'h00000000;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers in 64 us ticks
  rts_timer_if t1Bus ();
  rts_timer_if t2Bus ();
  rts_timer_if toBus ();
  rts_timer u_t1 (.sys_clk(sys_clk), .rst(rst), .bus(t1Bus.tmr));
  rts_timer u_t2 (.sys_clk(sys_clk), .rst(rst), .bus(t2Bus.tmr));
  rts_timer u_to (.sys_clk(sys_clk), .rst(rst), .bus(toBus.tmr));
  assign t1Bus.count = timer1Val;
  assign t2Bus.count = timer2Val;
  assign toBus.count = rxtoVal;
  wire t1Exp = t1Bus.expired;
  wire t2Exp = t2Bus.expired;
  wire toExp = toBus.expired;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  rts_pkg::rts_state_t next_state;
  logic preSeen;
  logic next_preSeen;
  logic toArmed;
  assign evSet = {t1Exp, toExp && toArmed, sentRise, syncRise, preRise};
  wire startSeq = hostStart && (start_transition == rts_pkg::START_TO_LPSEL);
  wire stopOnPre = (fromRx == rts_pkg::RX_OFF_ON_PRE) && preRise;
  wire stopOnSync = (fromRx == rts_pkg::RX_OFF_ON_SYNC) && syncRise;
  wire rxtoOk = (fromRxto == rts_pkg::RXTO_TO_LPSEL);
  wire rxtoLeave = toExp && toArmed && !preSeen && !preRise && rxtoOk;

  // Timers cycle first, second, first... while the sequencer runs, so the wake
  // period stays first plus second timer whichever event ends receive early
  wire t2Over = t2Exp && (state != rts_pkg::SEQ_OFF);
  // Second timer starts on first-timer expiry; receive timeout starts with receive
  assign t1Bus.load = (state == rts_pkg::SEQ_OFF && startSeq) || t2Over;
  assign t2Bus.load = t1Exp && (state == rts_pkg::SEQ_IDLE);
  assign toBus.load = t2Bus.load && idle_transition;

  // Timeout only counts before any preamble; the second timer still bounds receive
  always_ff @(posedge sys_clk) begin
    if (rst) toArmed <= 1'b0;
    else if (toBus.load) toArmed <= 1'b1;
    else if (toExp || state != rts_pkg::SEQ_RX) toArmed <= 1'b0;
  end

  always_comb begin
    next_state = state;
    next_preSeen = preSeen;
    case (state)
      rts_pkg::SEQ_OFF: begin
        if (startSeq) next_state = rts_pkg::SEQ_LPSEL;
      end
      rts_pkg::SEQ_LPSEL: begin
        next_preSeen = 1'b0;
        if (lpChoice) next_state = rts_pkg::SEQ_IDLE;
      end
      rts_pkg::SEQ_IDLE: begin
        if (t1Exp) next_state = idle_transition ? rts_pkg::SEQ_RX : rts_pkg::SEQ_TX;
      end
      rts_pkg::SEQ_RX: begin
        if (preRise) next_preSeen = 1'b1;
        if (stopOnPre) next_state = rts_pkg::SEQ_OFF;
        else if (stopOnSync) next_state = rts_pkg::SEQ_OFF;
        else if (rxtoLeave) next_state = rts_pkg::SEQ_LPSEL;
        else if (t2Exp) next_state = rts_pkg::SEQ_LPSEL;
      end
      rts_pkg::SEQ_TX: begin
        if (sentRise && !fromTx) next_state = rts_pkg::SEQ_LPSEL;
      end
      default: next_state = rts_pkg::SEQ_OFF;
    endcase
    if (hostHalt) next_state = rts_pkg::SEQ_OFF;
  end

  // Radio stays receiving after self-stop until host changes mode
  logic holdRx;
  wire selfStop = (state == rts_pkg::SEQ_RX) && (next_state == rts_pkg::SEQ_OFF);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= rts_pkg::SEQ_OFF;
      preSeen <= 1'b0;
      holdRx <= 1'b0;
    end else begin
      state <= next_state;
      preSeen <= next_preSeen;
      if (hostHalt || hostStart) holdRx <= 1'b0;
      else if (selfStop) holdRx <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Pin routing; a code other than the listed one keeps the pin low
  // Pin 4 has no code field: the map bit alone routes it
  wire [4:0] pinEv;
  assign pinEv[0] = (pinMap[1:0] == rts_pkg::PIN_MAP_01) && evSync[3];
  assign pinEv[1] = (pinMap[3:2] == rts_pkg::PIN_MAP_00) && evSync[4];
  assign pinEv[2] = (pinMap[5:4] == rts_pkg::PIN_MAP_11) && evSync[1];
  assign pinEv[3] = (pinMap[7:6] == rts_pkg::PIN_MAP_00) && evSync[5];
  assign pinEv[4] = pmapBit && evSync[0];
  wire idleSleep = (state == rts_pkg::SEQ_IDLE) && idleSel;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_on <= 1'b0;
      tx_on <= 1'b0;
      sleep_on <= 1'b0;
      rc_osc_only <= 1'b0;
      fifo_reuse <= 1'b0;
      gp_pin <= '0;
    end else begin
      rx_on <= (state == rts_pkg::SEQ_RX) || holdRx;
      tx_on <= (state == rts_pkg::SEQ_TX);
      sleep_on <= idleSleep;
      rc_osc_only <= idleSleep;
      fifo_reuse <= beaconEn;
      gp_pin <= pinEv;
    end
  end
endmodule : rts_top
`default_nettype wire

// *** test/rts_top_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module rts_top_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic packet_done_tx,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic sleep_on,
  input wire logic rc_osc_only,
  input wire logic fifo_reuse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  reuse_write_a: assert property ($changed(fifo_reuse)
    |-> $past(s_axi_awvalid) || $past(s_axi_awvalid, 2))
    else $error("fifo reuse changed without a write");
  rx_sleep_a: assert property ($rose(rx_on) |-> $past(sleep_on))
    else $error("receive entered not from idle");
  tx_sleep_a: assert property ($rose(tx_on) |-> $past(sleep_on))
    else $error("transmit entered not from idle");
  tx_sent_a: assert property ($fell(tx_on) |-> $past(packet_done_tx, 2))
    else $error("transmit left without packet done");
  sleep_rc_a: assert property (sleep_on |-> rc_osc_only && !rx_on && !tx_on)
    else $error("sleep idle with more than the RC oscillator");
  radio_excl_a: assert property (!(rx_on && tx_on))
    else $error("receive and transmit together");
endmodule : rts_top_props
bind rts_top rts_top_props rts_top_props_inst (.*);
`default_nettype wire

// *** test/rts_radio_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rts_radio_model (
  input wire logic sys_clk,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic [1:0] mode,
  output logic preamble_found,
  output logic sync_match,
  output logic packet_done_tx
);
  int rxCnt = 0;
  int txCnt = 0;
  initial begin
    preamble_found = 1'b0;
    sync_match = 1'b0;
    packet_done_tx = 1'b0;
  end
  // Mode 0 silent, 1 preamble only, 2 preamble then sync word
  always @(posedge sys_clk) begin
    rxCnt <= rx_on ? rxCnt + 1 : 0;
    txCnt <= tx_on ? txCnt + 1 : 0;
    preamble_found <= rx_on && mode != 2'h0 && rxCnt >= 20;
    sync_match <= rx_on && mode == 2'h2 && rxCnt >= 60;
    // Long pulse so the two-stage input sync cannot miss it
    packet_done_tx <= txCnt >= 30 && txCnt < 42;
  end
endmodule : rts_radio_model
`default_nettype wire

// *** test/rts_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module rts_top_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic preamble_found, sync_match, packet_done_tx;
  logic crc_good = 1'b0, fifo_threshold_flag = 1'b0, fifo_empty_flag = 1'b0;
  logic rx_on, tx_on, sleep_on, rc_osc_only, fifo_reuse, irq;
  logic [4:0] gp_pin;
  logic [1:0] mode = 2'h0;
  int nErrors = 0;
  int checksDone = 0;
  int n, tot;
  wire logic [3:0] outs;
  assign outs = {irq, sleep_on, tx_on, rx_on};
  rts_top rts_top_inst (.*);
  rts_radio_model rts_radio_model_inst (.*);
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic giveVerdict();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : giveVerdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    b = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (b !== 1'b1) begin
      @(negedge sys_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    v = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (v !== 1'b1) begin
      @(negedge sys_clk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(32'(r), 32'h0);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d & m, e);
  endtask : rdc
  // Counts cycles until one output reaches a level, then checks it got there
  task automatic waitOut(input int i, input logic v, input int lim, output int c);
    c = 0;
    while (outs[i] !== v && c < lim) begin
      @(negedge sys_clk);
      c++;
    end
    chk(32'(outs[i]), 32'(v));
  endtask : waitOut
  function automatic logic [31:0] ctl(input logic [2:0] frx, input logic fidle, input logic bcn);
    ctl = 32'h4825 | (32'(frx) << rts_pkg::CTRL_FRX_LO) | (32'(fidle) << rts_pkg::CTRL_FIDLE);
    ctl = ctl | (32'(bcn) << rts_pkg::CTRL_BEACON);
  endfunction : ctl
  ////////////////////////////////////////
  task automatic tReset();
    logic [31:0] d;
    logic [1:0] r;
    rdc(rts_pkg::ADDR_CTRL, 32'hFFFFFFFF, rts_pkg::CTRL_RESET);
    rdc(rts_pkg::ADDR_STATE, 32'hFF, 32'h0);
    chk(32'({outs, fifo_reuse}), 32'h0);
    axw(8'h24, 32'hFFFFFFFF, r);
    chk(32'(r), 32'h2);
    axr(8'h24, d, r);
    chk({d[29:0], r}, 32'h2);
    wr(rts_pkg::ADDR_FIRST_TIMER, 32'h1);
    wr(rts_pkg::ADDR_SECOND_TIMER, 32'h2);
    wr(rts_pkg::ADDR_RXTO, 32'h1);
    wr(rts_pkg::ADDR_IRQ_MASK, 32'h2);
    wr(rts_pkg::ADDR_PINMAP, 32'h31);
    rdc(rts_pkg::ADDR_PINMAP, 32'hFF, 32'h31);
  endtask : tReset
  task automatic tListen();
    wr(rts_pkg::ADDR_CTRL, ctl(rts_pkg::RX_OFF_ON_SYNC, 1'b1, 1'b0));
    waitOut(2, 1'b1, 8000, n);
    chk(32'(rc_osc_only), 32'h1);
    waitOut(0, 1'b1, 8000, n);
    waitOut(0, 1'b0, 4000, tot);
    chk(32'(tot < 2600), 32'h1);
    waitOut(2, 1'b1, 10, n);
    tot += n;
    waitOut(0, 1'b1, 11000, n);
    tot += n;
    chk(32'(tot > 6400 && tot <= 10240), 32'h1);
    mode = 2'h1;
    waitOut(0, 1'b0, 8000, n);
    chk(32'(n > 2600 && n <= 5300), 32'h1);
    waitOut(0, 1'b1, 11000, n);
    chk(32'(irq), 32'h0);
  endtask : tListen
  task automatic tSync();
    mode = 2'h2;
    @(posedge sys_clk);
    crc_good <= 1'b1;
    fifo_empty_flag <= 1'b1;
    waitOut(3, 1'b1, 9000, n);
    rdc(rts_pkg::ADDR_STATE, 32'hFF, 32'h0);
    chk(32'(gp_pin), 32'h1D);
    @(posedge sys_clk);
    crc_good <= 1'b0;
    fifo_threshold_flag <= 1'b1;
    fifo_empty_flag <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(32'(gp_pin), 32'h16);
    repeat (8000) @(negedge sys_clk);
    chk(32'(rx_on), 32'h1);
    rdc(rts_pkg::ADDR_STATE, 32'hFF, 32'h0);
    wr(rts_pkg::ADDR_IRQ_STAT, 32'h2);
    chk(32'(irq), 32'h0);
  endtask : tSync
  task automatic tPreStop();
    mode = 2'h1;
    wr(rts_pkg::ADDR_CTRL, ctl(rts_pkg::RX_OFF_ON_PRE, 1'b1, 1'b0));
    waitOut(2, 1'b1, 100, n);
    waitOut(0, 1'b1, 8000, n);
    repeat (3000) @(negedge sys_clk);
    chk(32'(rx_on), 32'h1);
    rdc(rts_pkg::ADDR_STATE, 32'hFF, 32'h0);
  endtask : tPreStop
  task automatic tBeacon();
    mode = 2'h0;
    wr(rts_pkg::ADDR_CTRL, ctl(3'h0, 1'b0, 1'b1));
    repeat (4) @(negedge sys_clk);
    chk(32'(fifo_reuse), 32'h1);
    waitOut(1, 1'b1, 8000, n);
    waitOut(1, 1'b0, 100, n);
    waitOut(2, 1'b1, 10, n);
    waitOut(1, 1'b1, 11000, n);
    chk(32'(n > 6000 && n <= 10240), 32'h1);
    waitOut(1, 1'b0, 100, n);
    wr(rts_pkg::ADDR_CTRL, (ctl(3'h0, 1'b0, 1'b1) ^ 32'h1) | 32'h2);
    repeat (8000) @(negedge sys_clk);
    chk(32'(tx_on), 32'h0);
    rdc(rts_pkg::ADDR_STATE, 32'hFF, 32'h0);
  endtask : tBeacon
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    tReset();
    tListen();
    tSync();
    tPreStop();
    tBeacon();
    giveVerdict();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    nErrors++;
    giveVerdict();
  end
endmodule : rts_top_tb
`default_nettype wire
